// >>> common/atasd_pkg.sv
// Constants and types for the drive-side task-file status block
package atasd_pkg;
	localparam logic [9:0] TF_ERR          = 10'h1f1;
	localparam logic [9:0] TF_CNT          = 10'h1f2;
	localparam logic [9:0] TF_SEL          = 10'h1f6;
	localparam logic [9:0] TF_STAT         = 10'h1f7;
	localparam int         TF_BLK_LSB      = 3;
	localparam int         ST_BUSY         = 7;
	localparam int         ST_RDY          = 6;
	localparam int         ST_XFER         = 3;
	localparam int         ST_ERR          = 0;
	localparam int         SEL_LBA         = 6;
	localparam int         ER_ABRT         = 2;
	localparam int         TAG_LSB         = 3;
	localparam logic [7:0] CMD_RD_Q        = 8'h60;
	localparam logic [7:0] CMD_WR_Q        = 8'h61;
	localparam logic [7:0] CMD_INIT_PARAM  = 8'h91;
	localparam logic [7:0] CMD_SET_FEAT    = 8'hef;
	localparam logic [7:0] FEAT_ENABLE     = 8'h10;
	localparam logic [7:0] FEAT_DISABLE    = 8'h90;
	localparam logic [7:0] SUB_AUTO_ACT    = 8'h02;
	localparam logic [7:0] LOG_NCQ_PAGE    = 8'h10;
	localparam logic [7:0] SEL_RST         = 8'h00;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;
	localparam logic [31:0] TAG_ONE        = 32'h0000_0001;
	localparam int         CLK_PERIOD_NS   = 10;
	localparam int         STATUS_VALID_NS = 400;
	// Longest time, so rounded down
	localparam int         STATUS_VALID_CYC = STATUS_VALID_NS / CLK_PERIOD_NS;
	localparam int         LOG_WORDS       = 4;
	localparam int         LOG_AW          = 2;
	localparam int         LOG_DW          = 32;

	typedef enum logic [0:0] {
		CS_IDLE = 1'b0,
		CS_BUSY = 1'b1
	} atasd_cmd_t;

	typedef enum logic [0:0] {
		PIN_STRAP = 1'b0,
		PIN_ACT   = 1'b1
	} atasd_pin_t;
endpackage

// >>> rtl/atasd_log_mem.sv
// Small error-log store with registered read data
`timescale 1ns/1ps
module atasd_log_mem
	import atasd_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic [LOG_AW-1:0] wr_addr,
	input  wire logic [LOG_DW-1:0] wr_data,
	input  wire logic [LOG_AW-1:0] rd_addr,
	output logic      [LOG_DW-1:0] rd_data_r
);
	logic [LOG_DW-1:0] mem [LOG_WORDS];

	// Write port; contents undefined until first log entry
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read every cycle so data lines up with the answer flag
	always_ff @(posedge clk) begin
		rd_data_r <= mem[rd_addr];
	end
endmodule

// >>> rtl/atasd_regs.sv
// Drive-side address select, status, activity pin and queued command tracking
`timescale 1ns/1ps
module atasd_regs
	import atasd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        tf_rd,
	input  wire logic        tf_wr,
	input  wire logic [9:0]  tf_addr,
	input  wire logic [7:0]  tf_wdata,
	output logic      [7:0]  tf_rdata_r,
	input  wire logic        core_ready,
	input  wire logic        xfer_ready,
	input  wire logic        cmd_done,
	input  wire logic        cmd_fail,
	input  wire logic [7:0]  fail_code,
	input  wire logic [3:0]  cur_addr_hi,
	output logic             cmd_start_r,
	output logic      [7:0]  cmd_code_r,
	output logic      [7:0]  addr_sel_r,
	output logic      [3:0]  heads_minus1_r,
	output logic             auto_act_r,
	output logic             intrq_r,
	input  wire logic        act_in,
	output logic             act_out_r,
	output logic             act_oe_n_r,
	input  wire logic        link_up,
	output logic             stagger_en_r,
	output logic             ncq_start_r,
	output logic      [4:0]  ncq_start_tag_r,
	input  wire logic        ncq_done,
	input  wire logic [4:0]  ncq_tag,
	input  wire logic        ncq_fail,
	output logic             sdb_send_r,
	output logic      [31:0] sdb_tags_r,
	output logic             sdb_err_r,
	input  wire logic        log_rd,
	input  wire logic [7:0]  log_page,
	input  wire logic [LOG_AW-1:0] log_index,
	output logic             log_ok_r,
	output logic [LOG_DW-1:0] log_data_r
);
	localparam int SETTLE_MAX = STATUS_VALID_CYC;

	atasd_cmd_t  cs_r;
	atasd_pin_t  pin_mode_r;
	logic        rdy_r, rdy_hold_r, xfer_r, err_r;
	logic [7:0]  err_code_r, cnt_r, feat_r, status;
	logic [31:0] outstanding_r;
	logic        act_s1_r, act_s2_r;
	logic        cb_wr, cmd_wr, stat_rd, queued, dup, mixed;
	logic        reject, q_accept, nq_accept, plain_done, err_set, irq_set;
	logic [4:0]  q_tag;
	logic        log_wr;
	logic [LOG_DW-1:0] log_word;

	// True for any address inside the command block
	function automatic logic in_cmd_block(input logic [9:0] a);
		return a[9:TF_BLK_LSB] == TF_STAT[9:TF_BLK_LSB];
	endfunction

	// Queued read or write opcode
	function automatic logic is_queued(input logic [7:0] op);
		return (op == CMD_RD_Q) || (op == CMD_WR_Q);
	endfunction

	// One-hot tag mask
	function automatic logic [31:0] tag_mask(input logic [4:0] t);
		return TAG_ONE << t;
	endfunction

	// bits settle together; other bits are registered, so valid as busy drops
	assign status = {cs_r == CS_BUSY, rdy_r, 2'b00, xfer_r, 2'b00, err_r};
	// Writes while busy are dropped; the host is not allowed to make them
	assign cb_wr      = tf_wr && in_cmd_block(tf_addr) && (cs_r == CS_IDLE);
	assign cmd_wr     = cb_wr && (tf_addr == TF_STAT);
	assign stat_rd    = tf_rd && (tf_addr == TF_STAT);
	assign queued     = is_queued(tf_wdata);
	assign q_tag      = cnt_r[TAG_LSB +: 5];
	assign dup        = queued && outstanding_r[q_tag];
	assign mixed      = !queued && (outstanding_r != '0);
	assign reject     = cmd_wr && (dup || mixed);
	assign q_accept   = cmd_wr && queued && !dup;
	assign nq_accept  = cmd_wr && !queued && !mixed;
	assign plain_done = cmd_done && (cs_r == CS_BUSY);
	assign err_set    = reject || (plain_done && cmd_fail) || (ncq_done && ncq_fail);
	assign irq_set    = reject || plain_done || ncq_done;
	assign log_wr     = ncq_done && ncq_fail;
	assign log_word   = {BYTE_ZERO, fail_code, 1'b0, rdy_r, 5'b00000, 1'b1, 3'b000, ncq_tag};

	// ownership from accepted plain command write until completion
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cs_r <= CS_IDLE;
		end else begin
			unique case (cs_r)
				CS_IDLE: begin
					if (nq_accept) begin
						cs_r <= CS_BUSY;
					end
				end
				CS_BUSY: begin
					if (cmd_done) begin
						cs_r <= CS_IDLE;
					end
				end
			endcase
		end
	end

	// Command hand-off to the drive core
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmd_start_r <= 1'b0;
			cmd_code_r  <= BYTE_ZERO;
		end else begin
			cmd_start_r <= nq_accept;
			if (nq_accept) begin
				cmd_code_r <= tf_wdata;
			end
		end
	end

	// Parameter registers written by the host
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r  <= BYTE_ZERO;
			feat_r <= BYTE_ZERO;
		end else begin
			if (cb_wr && tf_addr == TF_CNT) begin
				cnt_r <= tf_wdata;
			end
			if (cb_wr && tf_addr == TF_ERR) begin
				feat_r <= tf_wdata;
			end
		end
	end

	// address select; low nibble is head or address bits 24-27
	always_ff @(posedge clk) begin
		if (!resetn) begin
			addr_sel_r <= SEL_RST;
		end else if (plain_done) begin
			addr_sel_r[3:0] <= cur_addr_hi;
		end else if (cb_wr && tf_addr == TF_SEL) begin
			addr_sel_r <= tf_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			heads_minus1_r <= 4'h0;
		end else if (nq_accept && tf_wdata == CMD_INIT_PARAM) begin
			heads_minus1_r <= addr_sel_r[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			auto_act_r <= 1'b0;
		end else if (nq_accept && tf_wdata == CMD_SET_FEAT && cnt_r == SUB_AUTO_ACT) begin
			if (feat_r == FEAT_ENABLE) begin
				auto_act_r <= 1'b1;
			end else if (feat_r == FEAT_DISABLE) begin
				auto_act_r <= 1'b0;
			end
		end
	end

	// error flag and cause; a new error beats a clearing command
	always_ff @(posedge clk) begin
		if (!resetn) begin
			err_r      <= 1'b0;
			err_code_r <= BYTE_ZERO;
		end else if (err_set) begin
			err_r <= 1'b1;
			if (reject) begin
				err_code_r <= BYTE_ZERO | (8'h01 << ER_ABRT);
			end else begin
				err_code_r <= fail_code;
			end
		end else if (q_accept || nq_accept) begin
			err_r      <= 1'b0;
			err_code_r <= BYTE_ZERO;
		end
	end

	// ready frozen on error until the host reads status; set wins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdy_hold_r <= 1'b0;
		end else if (err_set) begin
			rdy_hold_r <= 1'b1;
		end else if (stat_rd) begin
			rdy_hold_r <= 1'b0;
		end
	end

	// ready clear from reset; transfer request follows the core
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdy_r  <= 1'b0;
			xfer_r <= 1'b0;
		end else begin
			xfer_r <= xfer_ready;
			if (!rdy_hold_r || stat_rd) begin
				rdy_r <= core_ready;
			end
		end
	end

	// pending interrupt; a new event in the ack cycle survives
	always_ff @(posedge clk) begin
		if (!resetn) begin
			intrq_r <= 1'b0;
		end else if (irq_set) begin
			intrq_r <= 1'b1;
		end else if (stat_rd) begin
			intrq_r <= 1'b0;
		end
	end

	// read data; whole block reads back status while busy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tf_rdata_r <= BYTE_ZERO;
		end else if (tf_rd && in_cmd_block(tf_addr)) begin
			if (cs_r == CS_BUSY || tf_addr == TF_STAT) begin
				tf_rdata_r <= status;
			end else if (tf_addr == TF_ERR) begin
				tf_rdata_r <= err_code_r;
			end else if (tf_addr == TF_CNT) begin
				tf_rdata_r <= cnt_r;
			end else if (tf_addr == TF_SEL) begin
				tf_rdata_r <= addr_sel_r;
			end else begin
				tf_rdata_r <= BYTE_ZERO;
			end
		end else begin
			tf_rdata_r <= BYTE_ZERO;
		end
	end

	// queued tag tracking; completion clears after a same-tag issue
	always_ff @(posedge clk) begin
		if (!resetn) begin
			outstanding_r   <= '0;
			ncq_start_r     <= 1'b0;
			ncq_start_tag_r <= 5'h00;
		end else begin
			ncq_start_r <= q_accept;
			if (q_accept) begin
				ncq_start_tag_r <= q_tag;
			end
			outstanding_r <= (outstanding_r | (q_accept ? tag_mask(q_tag) : '0))
				& ~(ncq_done ? tag_mask(ncq_tag) : '0);
		end
	end

	// device-bits report; completion outranks a duplicate report
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sdb_send_r <= 1'b0;
			sdb_tags_r <= '0;
			sdb_err_r  <= 1'b0;
		end else begin
			sdb_send_r <= ncq_done || (cmd_wr && dup);
			if (ncq_done) begin
				sdb_tags_r <= tag_mask(ncq_tag);
				sdb_err_r  <= ncq_fail;
			end else if (cmd_wr && dup) begin
				sdb_tags_r <= '0;
				sdb_err_r  <= 1'b1;
			end
		end
	end

	// answer flag for the queued-error log page
	always_ff @(posedge clk) begin
		if (!resetn) begin
			log_ok_r <= 1'b0;
		end else begin
			log_ok_r <= log_rd && (log_page == LOG_NCQ_PAGE);
		end
	end

	// log store; newest failure replaces word 0
	atasd_log_mem u_log (
		.clk       (clk),
		.wr_en     (log_wr),
		.wr_addr   ('0),
		.wr_data   (log_word),
		.rd_addr   (log_index),
		.rd_data_r (log_data_r)
	);

	// Pin synchroniser; only the second stage is read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			act_s1_r <= 1'b1;
			act_s2_r <= 1'b1;
		end else begin
			act_s1_r <= act_in;
			act_s2_r <= act_s1_r;
		end
	end

	// strap sampled until link up, then pin becomes activity
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_mode_r   <= PIN_STRAP;
			stagger_en_r <= 1'b1;
			act_oe_n_r   <= 1'b1;
			act_out_r    <= 1'b0;
		end else begin
			act_out_r <= 1'b0;
			unique case (pin_mode_r)
				PIN_STRAP: begin
					stagger_en_r <= act_s2_r;
					act_oe_n_r   <= 1'b1;
					if (link_up) begin
						pin_mode_r <= PIN_ACT;
					end
				end
				PIN_ACT: begin
					// open-drain low while any command active
					act_oe_n_r <= !((cs_r == CS_BUSY) || (outstanding_r != '0));
				end
			endcase
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_dup_cmd;
		cmd_wr && dup;
	endsequence
	sequence s_err_report;
		err_r && err_code_r[ER_ABRT] && intrq_r;
	endsequence
	sequence s_plain_done;
		plain_done && !err_set;
	endsequence

	property p_busy_read;
		(cs_r == CS_BUSY) && tf_rd && in_cmd_block(tf_addr) |=> tf_rdata_r == $past(status);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy read not status");
	property p_irq_ack;
		stat_rd && !irq_set |=> !intrq_r;
	endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("interrupt not acked");
	property p_rdy_hold;
		rdy_hold_r && !stat_rd |=> $stable(rdy_r);
	endproperty
	a_rdy_hold: assert property (p_rdy_hold) else $error("ready moved during hold");
	property p_own;
		nq_accept |=> (cs_r == CS_BUSY) && cmd_start_r ##0 status[ST_BUSY];
	endproperty
	a_own: assert property (p_own) else $error("busy not set");
	property p_dup;
		s_dup_cmd |=> s_err_report and sdb_send_r;
	endproperty
	a_dup: assert property (p_dup) else $error("duplicate tag not reported");
	property p_mix;
		cmd_wr && mixed |=> s_err_report and (cs_r == CS_IDLE);
	endproperty
	a_mix: assert property (p_mix) else $error("mixed command not refused");
	property p_settle;
		plain_done && cmd_fail |=> ##[0:SETTLE_MAX] status[ST_ERR];
	endproperty
	a_settle: assert property (p_settle) else $error("error bit late");
	property p_sdb;
		ncq_done |=> sdb_send_r && sdb_tags_r == tag_mask($past(ncq_tag))
			&& sdb_err_r == $past(ncq_fail);
	endproperty
	a_sdb: assert property (p_sdb) else $error("completion report wrong");
	property p_addr_upd;
		s_plain_done |=> addr_sel_r[3:0] == $past(cur_addr_hi) ##1 status[ST_BUSY] == 1'b0;
	endproperty
	a_addr_upd: assert property (p_addr_upd) else $error("address not updated");
	property p_strap;
		pin_mode_r == PIN_STRAP |=> act_oe_n_r;
	endproperty
	a_strap: assert property (p_strap) else $error("pin driven during strap");
endmodule

// >>> testbench/atasd_far_model.sv
// Far side model: host strap on the shared pin and a core that finishes commands
`timescale 1ns/1ps
module atasd_far_model #(
	parameter int DLY = 8
) (
	input  wire logic clk,
	input  wire logic cmd_start_r,
	input  wire logic strap_low,
	input  wire logic act_oe_n_r,
	output logic      act_in,
	output logic      cmd_done
);
	int cnt = 0;
	// pin resolution
	// Pull-up wins when nobody drives low, so an open strap reads high
	assign act_in = (strap_low || !act_oe_n_r) ? 1'b0 : 1'b1;
	// Core ends each accepted plain command after a fixed delay
	initial cmd_done = 1'b0;
	always @(posedge clk) begin
		cmd_done <= (cnt == 1);
		if (cmd_start_r)
			cnt <= DLY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the drive-side status block
`timescale 1ns/1ps
module tb;
	import atasd_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, tf_rd = 1'b0, tf_wr = 1'b0;
	logic [9:0] tf_addr = '0;
	logic [7:0] tf_wdata = '0, fail_code = '0, log_page = '0, tf_rdata_r, cmd_code_r, addr_sel_r;
	logic core_ready = 1'b0, xfer_ready = 1'b0, cmd_fail = 1'b0, link_up = 1'b0;
	logic strap_low = 1'b0, ncq_done = 1'b0, ncq_fail = 1'b0, log_rd = 1'b0;
	logic [3:0] cur_addr_hi = '0, heads_minus1_r;
	logic [4:0] ncq_tag = '0, ncq_start_tag_r;
	logic [LOG_AW-1:0] log_index = '0;
	logic cmd_done, cmd_start_r, auto_act_r, intrq_r, act_in, act_out_r, act_oe_n_r;
	logic stagger_en_r, ncq_start_r, sdb_send_r, sdb_err_r, log_ok_r;
	logic [31:0] sdb_tags_r;
	logic [LOG_DW-1:0] log_data_r;
	logic [7:0] d;
	int fails = 0, checks_done = 0, cyc = 0;

	atasd_regs dut (.clk, .resetn, .tf_rd, .tf_wr, .tf_addr, .tf_wdata, .tf_rdata_r,
		.core_ready, .xfer_ready, .cmd_done, .cmd_fail, .fail_code, .cur_addr_hi,
		.cmd_start_r, .cmd_code_r, .addr_sel_r, .heads_minus1_r, .auto_act_r, .intrq_r,
		.act_in, .act_out_r, .act_oe_n_r, .link_up, .stagger_en_r, .ncq_start_r,
		.ncq_start_tag_r, .ncq_done, .ncq_tag, .ncq_fail, .sdb_send_r, .sdb_tags_r,
		.sdb_err_r, .log_rd, .log_page, .log_index, .log_ok_r, .log_data_r);

	atasd_far_model far (.clk, .cmd_start_r, .strap_low, .act_oe_n_r, .act_in, .cmd_done);

	always #5 clk = ~clk;

	// Hang guard far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One strobe cycle; data lands the cycle after the taking edge
	task automatic rd(input logic [9:0] a, output logic [7:0] q);
		@(posedge clk);
		tf_rd <= 1'b1;
		tf_addr <= a;
		@(posedge clk);
		tf_rd <= 1'b0;
		#1 q = tf_rdata_r;
	endtask

	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] q;
		rd(a, q);
		chk(q, e);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		tf_wr <= 1'b1;
		tf_addr <= a;
		tf_wdata <= v;
		@(posedge clk);
		tf_wr <= 1'b0;
		#1;
	endtask

	// Bounded wait for the completion interrupt
	// host waits out busy
	task automatic wait_irq();
		int n;
		n = 0;
		while (intrq_r !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		chk(intrq_r, 1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		tick(2);
		rchk(TF_STAT, 8'h00);
		chk(auto_act_r, 0);
		chk(addr_sel_r, SEL_RST);
		chk(stagger_en_r, 1);
		// Strap sampled until the link comes up, frozen afterwards
		@(posedge clk) strap_low <= 1'b1;
		tick(5);
		chk(stagger_en_r, 0);
		@(posedge clk) strap_low <= 1'b0;
		tick(5);
		chk(stagger_en_r, 1);
		@(posedge clk) link_up <= 1'b1;
		tick(2);
		@(posedge clk) strap_low <= 1'b1;
		tick(5);
		chk(stagger_en_r, 1);
		@(posedge clk) strap_low <= 1'b0;
		tick(2);
		chk(act_oe_n_r, 1);
		@(posedge clk) begin
			core_ready <= 1'b1;
			cur_addr_hi <= 4'h5;
		end
		tick(2);
		rchk(TF_STAT, 8'h40);
		wr(TF_SEL, 8'h03);
		chk(addr_sel_r, 8'h03);
		wr(TF_SEL, 8'h4a);
		rchk(TF_SEL, 8'h4a);
		// Plain command: busy, shadowed reads, completion
		wr(TF_STAT, 8'hc8);
		chk({cmd_start_r, cmd_code_r}, 9'h1c8);
		rd(TF_SEL, d);
		chk(d[ST_BUSY], 1);
		chk(act_oe_n_r, 0);
		chk(act_out_r, 0);
		wait_irq();
		chk(addr_sel_r, 8'h45);
		rchk(TF_STAT, 8'h40);
		chk(intrq_r, 0);
		@(posedge clk) xfer_ready <= 1'b1;
		tick(2);
		rchk(TF_STAT, 8'h48);
		// Failed command, then readiness drops before the host looks
		@(posedge clk) begin
			xfer_ready <= 1'b0;
			cmd_fail <= 1'b1;
			fail_code <= 8'h14;
		end
		wr(TF_STAT, 8'hc8);
		wait_irq();
		@(posedge clk) begin
			core_ready <= 1'b0;
			cmd_fail <= 1'b0;
		end
		tick(2);
		rchk(TF_STAT, 8'h41);
		rchk(TF_STAT, 8'h01);
		rchk(TF_ERR, 8'h14);
		@(posedge clk) core_ready <= 1'b1;
		wr(TF_SEL, 8'h03);
		wr(TF_STAT, CMD_INIT_PARAM);
		wait_irq();
		chk(heads_minus1_r, 4'h3);
		rchk(TF_STAT, 8'h40);
		// Auto-activate on, then off again
		for (int i = 0; i < 2; i++) begin
			wr(TF_ERR, (i == 0) ? FEAT_ENABLE : FEAT_DISABLE);
			wr(TF_CNT, SUB_AUTO_ACT);
			wr(TF_STAT, CMD_SET_FEAT);
			wait_irq();
			chk(auto_act_r, (i == 0));
			rd(TF_STAT, d);
		end
		// Queued read with tag 5, duplicate tag, mixed plain command
		wr(TF_CNT, 8'h28);
		wr(TF_STAT, CMD_RD_Q);
		chk({ncq_start_r, ncq_start_tag_r}, 6'h25);
		tick(2);
		chk(act_oe_n_r, 0);
		wr(TF_STAT, CMD_WR_Q);
		chk(ncq_start_r, 0);
		chk({sdb_send_r, sdb_err_r}, 2'h3);
		chk(sdb_tags_r, 32'h0000_0000);
		rchk(TF_STAT, 8'h41);
		rchk(TF_ERR, 8'h04);
		wr(TF_STAT, 8'hc8);
		chk({cmd_start_r, intrq_r}, 2'b01);
		rchk(TF_STAT, 8'h41);
		// Failed queued completion reported as device bits and logged
		@(posedge clk) begin
			fail_code <= 8'h33;
			ncq_tag <= 5'd5;
			ncq_fail <= 1'b1;
			ncq_done <= 1'b1;
		end
		@(posedge clk) ncq_done <= 1'b0;
		#1 chk({sdb_send_r, sdb_err_r}, 2'h3);
		chk(sdb_tags_r, 32'h0000_0020);
		chk(intrq_r, 1);
		tick(2);
		chk(act_oe_n_r, 1);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) begin
				log_rd <= 1'b1;
				log_page <= LOG_NCQ_PAGE + 8'(i);
			end
			@(posedge clk) log_rd <= 1'b0;
			#1 chk(log_ok_r, (i == 0));
			if (i == 0)
				chk(log_data_r, 32'h0033_4105);
		end
		finish_test();
	end
endmodule
